/* File: boundary_scan_adc_chain_test.sv */
// boundary_scan_adc_chain_test.sv - bench joining both chain ends
`timescale 1ns/1ps
`default_nettype none
`include "bsc_params.svh"
module boundary_scan_adc_chain_test import bsc_pkg::*;;
   typedef struct packed {
      logic [9:0] dac; // comparison value
      logic [4:0] f;   // hold, precharge, raw, check, latch
   } bsc_row_t;
   localparam bsc_vec_t  OBS  = {47{3'h5}};  // observed cells
   localparam bsc_pins_t PINS = 32'h5AC396E1; // pin levels
   logic       clk, arst_n, start, extest_in, conv_en, cmp_raw, e;
   logic       done, err, sample_hold, latch_precharge_n_n, conv_busy, cmp_latch;
   logic       cmp_res, conv_on; // scanned result, enable seen
   logic [2:0] neg_sel;          // negative select seen
   logic [9:0] dac_value;      // converter value seen
   logic [7:0] channel_select; // channel seen
   bsc_vec_t   vec_in, vec_out, cell_q, snap;
   int         mismatches, comparisons, i;
   // limit check: lower then upper pass
   bsc_row_t   rows [11] = '{'{10'h200, 5'h18}, '{10'h200, 5'h08},
      '{10'h200, 5'h18}, '{10'h123, 5'h18}, '{10'h123, 5'h12},
      '{10'h200, 5'h1A}, '{10'h200, 5'h0C}, '{10'h200, 5'h1C},
      '{10'h143, 5'h1C}, '{10'h143, 5'h16}, '{10'h200, 5'h1F}};
   bsc_link_if link ();
   bsc_dev_end bsc_dev_end_inst (.clk(clk), .arst_n(arst_n), .link(link),
      .obs_in(OBS), .pin_in(PINS), .cpu_pin_out(32'h0), .cpu_pin_oe(32'h0),
      .cpu_pin_pull(32'h0), .cpu_conv_enable(conv_en), .cmp_raw(cmp_raw),
      .pin_out(), .pin_oe(), .pin_pull(), .cell_q(cell_q),
      .conv_enable(conv_on), .dac_value(dac_value),
      .channel_select(channel_select),
      .neg_input_select(neg_sel), .sample_hold(sample_hold),
      .latch_precharge_n(latch_precharge_n_n), .conv_busy(conv_busy),
      .cmp_latch(cmp_latch));
   bsc_host_end bsc_host_end_inst (.clk(clk), .arst_n(arst_n), .link(link),
      .start(start), .extest_in(extest_in), .vec_in(vec_in), .busy(),
      .done(done), .err(err), .vec_out(vec_out), .cmp_result(cmp_res));
   bsc_chk bsc_chk_inst (.clk(clk), .arst_n(arst_n), .tck(link.tck),
      .tdi(link.tdi), .tdo(link.tdo), .shift_en(link.shift_en),
      .capture_en(link.capture_en), .update_en(link.update_en),
      .extest(link.extest));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic final_report;
      if (mismatches == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input bsc_vec_t x, input bsc_vec_t g);
      comparisons++;
      if (g !== x) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", nm, x, g);
      end
   endtask
   // idle vector, converter on, channel three, value, hold, precharge
   function automatic bsc_vec_t mk(input logic [9:0] d, input logic [1:0] hp);
      bsc_vec_t r;
      r = `BSC_UPD_RST & ~(141'h1 << 105) | (141'h1 << 108) | (141'h1 << 130);
      r[128:119] = d;
      r[114] = hp[1];
      r[100] = hp[0];
      return r;
   endfunction
   // one vector through the chain, bounded wait
   task automatic xfer(input logic x, input bsc_vec_t v, output logic r);
      int n;
      @(posedge clk);
      #1 start = 1'h1;
      extest_in = x;
      vec_in = v;
      @(posedge clk);
      #1 start = 1'h0;
      for (n = 0; !(done | err) && n < 3000; n++) begin
         @(posedge clk);
         #1;
      end
      r = err;
      if (n == 3000) begin
         mismatches++;
         final_report();
      end
   endtask
   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   initial begin
      arst_n = 1'h0;
      start = 1'h0;
      extest_in = 1'h0;
      vec_in = '0;
      conv_en = 1'h0;
      cmp_raw = 1'h0;
      repeat (3) @(posedge clk);
      #1 arst_n = 1'h1;
      chk("reset cells", `BSC_UPD_RST, cell_q);
      // ordinary rows
      for (i = 0; i < 11; i++) begin
         cmp_raw = rows[i].f[2];
         xfer(i != 0, mk(rows[i].dac, rows[i].f[4:3]), e);
         repeat (8) @(posedge clk);
         #1 chk("row refused", 1'h0, e);
         if (i != 0) begin
            chk("dac", rows[i].dac, dac_value);
            chk("hold", rows[i].f[4], sample_hold);
            chk("precharge", rows[i].f[3], latch_precharge_n_n);
            chk("channel", 8'h08, channel_select);
            chk("enable", 1'h1, conv_on);
            chk("neg select", 3'h0, neg_sel);
         end
         if (rows[i].f[1])
            chk("latch", rows[i].f[0], cmp_latch);
         // restoring vectors: bit scanned out is the verdict
         if (rows[i].f[1] && rows[i].f[3])
            chk("scanned result", rows[i].f[0], cmp_res);
      end
      // capture in normal mode, reserved bits offered as one
      xfer(1'h0, mk(10'h200, 2'h3) | (141'h1 << 135) | (141'h1 << 132), e);
      chk("comparator cells", OBS[140:137], vec_out[140:137]);
      chk("converter cells", OBS[131:97], vec_out[131:97]);
      chk("pin data", {PINS[1][0], PINS[3][0], PINS[2][6], PINS[0][7],
          PINS[0][0]}, {vec_out[96], vec_out[61], vec_out[31], vec_out[23],
          vec_out[2]});
      // dummy conversion on enable
      conv_en = 1'h1;
      repeat (5) @(posedge clk);
      #1 chk("busy in dummy", 1'h1, conv_busy);
      repeat (45) @(posedge clk);
      #1 chk("busy after dummy", 1'h0, conv_busy);
      // refused vectors leave the cells alone
      snap = cell_q;
      xfer(1'h1, mk(10'h123, 2'h1), e);
      chk("off mid", 1'h1, e);
      xfer(1'h1, mk(10'h200, 2'h3) | (141'h1 << 115) | (141'h1 << 131), e);
      chk("two sources", 1'h1, e);
      xfer(1'h1, mk(10'h200, 2'h3) | (141'h1 << 9), e);
      chk("pulled pin", 1'h1, e);
      chk("cells kept", snap, cell_q);
      final_report();
   end
endmodule // boundary_scan_adc_chain_test
`default_nettype wire

/* File: bsc_chk.sv */
// bsc_chk.sv - assertions on the scan link between the two ends
`timescale 1ns/1ps
`default_nettype none
module bsc_chk (
   input wire logic clk,        // system clock
   input wire logic arst_n,     // async reset, low
   input wire logic tck,        // test clock
   input wire logic tdi,        // bits into chain
   input wire logic tdo,        // bits out of chain
   input wire logic shift_en,   // shift qualifier
   input wire logic capture_en, // capture qualifier
   input wire logic update_en,  // update qualifier
   input wire logic extest      // cells drive device
);
   // ------------------------------------------------------------
   // shift tracking
   // ------------------------------------------------------------
   logic         tck_q;                // tck one clock ago
   logic [7:0]   cnt_q;                // shift rises since capture
   logic [140:0] sr_q;                 // copy of bits shifted in
   wire logic    rise = tck & ~tck_q;  // tck rise seen now
   // last tck level
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n)
         tck_q <= 1'h0;
      else
         tck_q <= tck;
   // count shifted bits and keep them
   always_ff @(posedge clk or negedge arst_n)
      if (!arst_n) begin
         cnt_q <= 8'h00;
         sr_q <= '0;
      end else if (rise && capture_en) begin
         cnt_q <= 8'h00;
      end else if (rise && shift_en) begin
         cnt_q <= cnt_q + 8'h01;
         sr_q <= {tdi, sr_q[140:1]};
      end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_len; rise && update_en |-> cnt_q == 8'h8D; endproperty
   a_len: assert property (p_len) else $error("bad shift count");
   property p_rsv_a; rise && shift_en && cnt_q == 8'h87 |-> !tdi; endproperty
   a_rsv_a: assert property (p_rsv_a) else $error("cell a not 0");
   property p_rsv_b; rise && shift_en && cnt_q == 8'h84 |-> !tdi; endproperty
   a_rsv_b: assert property (p_rsv_b) else $error("cell b not 0");
   property p_mid;
      rise && update_en && !sr_q[114] |-> sr_q[128:119] == 10'h200;
   endproperty
   a_mid: assert property (p_mid) else $error("sampling off mid");
   property p_src;
      rise && update_en |-> $countones({sr_q[115], sr_q[131],
                                        |sr_q[104:102]}) <= 1;
   endproperty
   a_src: assert property (p_src) else $error("two neg sources");
   property p_pin;
      rise && update_en && sr_q[130] && sr_q[108] |-> sr_q[11:9] == 3'h0;
   endproperty
   a_pin: assert property (p_pin) else $error("channel pin driven");
   property p_ord;
      rise |-> !(shift_en && (capture_en || update_en));
   endproperty
   a_ord: assert property (p_ord) else $error("controls overlap");
   property p_setup; $rose(tck) |-> $stable(tdi) && $stable(shift_en); endproperty
   a_setup: assert property (p_setup) else $error("data moved");
   property p_tck; $rose(tck) |-> tck[*8] ##1 !tck; endproperty
   a_tck: assert property (p_tck) else $error("tck high time");
   // main scenarios
   c_upd: cover property (rise && update_en && extest);
   c_cap: cover property (rise && capture_en && !extest);
   c_out: cover property (rise && shift_en && tdo);
endmodule // bsc_chk
`default_nettype wire

/* File: bsc_dev_end.sv */
// bsc_dev_end.sv - device end: boundary chain with converter cells
`timescale 1ns/1ps
`default_nettype none
`include "bsc_params.svh"

module bsc_dev_end
   import bsc_pkg::*;
(
   input  wire logic      clk,             // system clock
   input  wire logic      arst_n,          // async reset, low
   bsc_link_if.dev        link,            // scan link
   input  wire bsc_vec_t  obs_in,          // observed cell values
   input  wire bsc_pins_t pin_in,          // pin levels
   input  wire bsc_pins_t cpu_pin_out,     // functional pin data
   input  wire bsc_pins_t cpu_pin_oe,      // functional direction
   input  wire bsc_pins_t cpu_pin_pull,    // functional pull-up
   input  wire logic      cpu_conv_enable, // functional enable
   input  wire logic      cmp_raw,         // analog comparator
   output bsc_pins_t      pin_out,         // pin data
   output bsc_pins_t      pin_oe,          // pin drive enable
   output bsc_pins_t      pin_pull,        // pin pull-up enable
   output bsc_vec_t       cell_q,          // update register
   output logic           conv_enable,     // converter enable
   output logic [9:0]     dac_value,       // comparison value
   output logic [7:0]     channel_select,  // channel select
   output logic [2:0]     neg_input_select,// negative select
   output logic           sample_hold,     // high holds
   output logic           latch_precharge_n,// precharge, low
   output logic           conv_busy,       // dummy conversion
   output logic           cmp_latch        // comparator latch
);

   // ---------------------------------------------------------
   // link synchroniser
   // ---------------------------------------------------------
   logic [5:0] ln_s1_q;    // first stage
   logic [5:0] ln_s2_q;    // second stage
   logic       tck_s3_q;   // edge finder
   logic       tck_rise;   // tck rose
   logic       tck_fall;   // tck fell
   logic       tdi_s;      // synced data in
   logic       shift_s;    // synced shift
   logic       cap_s;      // synced capture
   logic       upd_s;      // synced update
   logic       extest_s;   // synced mode

   // two flops on every link input
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ln_s1_q  <= 6'h00;
         ln_s2_q  <= 6'h00;
         tck_s3_q <= 1'b0;
      end else begin
         ln_s1_q  <= {link.tck, link.tdi, link.shift_en,
                      link.capture_en, link.update_en, link.extest};
         ln_s2_q  <= ln_s1_q;
         tck_s3_q <= ln_s2_q[5];
      end
   end

   assign tck_rise = ln_s2_q[5] & ~tck_s3_q;
   assign tck_fall = ~ln_s2_q[5] & tck_s3_q;
   assign tdi_s    = ln_s2_q[4];
   assign shift_s  = ln_s2_q[3];
   assign cap_s    = ln_s2_q[2];
   assign upd_s    = ln_s2_q[1];
   assign extest_s = ln_s2_q[0];

   // ---------------------------------------------------------
   // pin cell map
   // ---------------------------------------------------------
   // data cell of a pin; port index a=0 b=1 c=2 d=3
   function automatic int pin_pos(input int p, input int b);
      int r;
      r = 0;
      case (p)
         0: r = `BSC_BASE_PA7 - 3 * (7 - b);
         1: r = `BSC_BASE_PB - 3 * b;
         2: r = (b < 2) ? `BSC_BASE_PC - 3 * b
                        : `BSC_BASE_PC6 - 3 * (b - 6);
         default: r = `BSC_BASE_PD - 3 * b;
      endcase
      return r;
   endfunction

   // port c bits two to five carry the tap pins
   function automatic logic has_cell(input int p, input int b);
      return !(p == 2 && b >= 2 && b <= 5);
   endfunction

   // ---------------------------------------------------------
   // comparator latch
   // ---------------------------------------------------------
   logic [32:0] in_s1_q; // first stage: pins, comparator
   logic [32:0] in_s2_q; // second stage: pins, comparator
   logic cmp_latch_q;  // resolved comparator
   logic latch_precharge_n_rel_q;  // latch already resolved
   logic latch_precharge_n_n;      // effective precharge

   assign latch_precharge_n_n = extest_s ? cell_q[`BSC_POS_LATCH_PRECHARGE_N] : 1'b1;

   // two flops on pin levels and the analog comparator
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         in_s1_q <= 33'h0;
         in_s2_q <= 33'h0;
      end else begin
         in_s1_q <= {pin_in, cmp_raw};
         in_s2_q <= in_s1_q;
      end
   end

   // precharge clears, release resolves once
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cmp_latch_q <= 1'b0;
         latch_precharge_n_rel_q <= 1'b1;
      end else if (!latch_precharge_n_n) begin
         cmp_latch_q <= 1'b0;
         latch_precharge_n_rel_q <= 1'b0;
      end else if (!latch_precharge_n_rel_q) begin
         cmp_latch_q <= in_s2_q[0];
         latch_precharge_n_rel_q <= 1'b1;
      end
   end

   assign cmp_latch = cmp_latch_q;

   // ---------------------------------------------------------
   // capture image
   // ---------------------------------------------------------
   bsc_vec_t cap_vec;  // value loaded at capture

   // observed values, pin levels and comparator
   always_comb begin
      cap_vec = obs_in;
      cap_vec[`BSC_POS_CMP] = in_s2_q[0];
      for (int p = 0; p < 4; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (has_cell(p, b)) begin
               cap_vec[pin_pos(p, b)] = in_s2_q[8 * p + b + 1];
            end
         end
      end
   end

   // ---------------------------------------------------------
   // shift and update registers
   // ---------------------------------------------------------
   bsc_vec_t sr_q;     // shift stage
   logic     tdo_q;    // serial out

   // capture or shift on tck rise, cell zero nearest tdo
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sr_q <= '0;
      end else if (tck_rise && cap_s) begin
         sr_q <= cap_vec;
      end else if (tck_rise && shift_s) begin
         sr_q <= {tdi_s, sr_q[140:1]};
      end
   end

   // tdo changes on tck fall, stable at next rise
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tdo_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_q <= sr_q[0];
      end
   end

   assign link.tdo = tdo_q;

   // all cells update at once
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cell_q <= `BSC_UPD_RST;
      end else if (tck_rise && upd_s) begin
         cell_q <= sr_q;
      end
   end

   // ---------------------------------------------------------
   // converter controls
   // ---------------------------------------------------------
   // converter field slices of the update register; enable, hold and precharge come from cells only in extest
   always_comb begin
      conv_enable      = extest_s ? cell_q[`BSC_POS_CONVERTER_ENABLE]
                                  : cpu_conv_enable;
      dac_value        = cell_q[`BSC_POS_DAC_HI:`BSC_POS_DAC_LO];
      channel_select   = cell_q[`BSC_POS_CHAN_HI:`BSC_POS_CHAN_LO];
      neg_input_select = cell_q[`BSC_POS_NEG_HI:`BSC_POS_NEG_LO];
      sample_hold      = extest_s ? cell_q[`BSC_POS_HOLD] : 1'b1;
      latch_precharge_n = latch_precharge_n_n;
   end

   // ---------------------------------------------------------
   // dummy conversion
   // ---------------------------------------------------------
   logic       en_prev_q;   // enable one cycle ago
   logic [3:0] cmp_left_q;  // comparisons remaining
   logic [2:0] sub_q;       // cycles inside a comparison

   // ten comparisons after enable rises in normal mode
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         en_prev_q  <= 1'b0;
         cmp_left_q <= 4'h0;
         sub_q      <= 3'h0;
      end else begin
         en_prev_q <= cpu_conv_enable;
         if (!extest_s && cpu_conv_enable && !en_prev_q) begin
            cmp_left_q <= 4'(`BSC_DUMMY_CMPS);
            sub_q      <= 3'h0;
         end else if (!cpu_conv_enable) begin
            cmp_left_q <= 4'h0;                       // disable aborts
         end else if (cmp_left_q != 4'h0) begin
            if (sub_q == 3'(`BSC_CMP_CYC - 1)) begin
               sub_q      <= 3'h0;
               cmp_left_q <= cmp_left_q - 4'h1;
            end else begin
               sub_q <= sub_q + 3'h1;
            end
         end
      end
   end

   assign conv_busy = (cmp_left_q != 4'h0);

   // ---------------------------------------------------------
   // pin drivers
   // ---------------------------------------------------------
   // extest drives from cells, else functional values; tap pins held at zero
   always_comb begin
      pin_out  = cpu_pin_out;
      pin_oe   = cpu_pin_oe;
      pin_pull = cpu_pin_pull;
      for (int p = 0; p < 4; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (!has_cell(p, b)) begin
               pin_out[p][b]  = 1'b0;
               pin_oe[p][b]   = 1'b0;
               pin_pull[p][b] = 1'b0;
            end else if (extest_s) begin
               pin_out[p][b]  = cell_q[pin_pos(p, b)];
               pin_oe[p][b]   = cell_q[pin_pos(p, b) - 1];
               pin_pull[p][b] = cell_q[pin_pos(p, b) - 2];
            end
         end
      end
   end

endmodule // bsc_dev_end
`default_nettype wire

/* File: bsc_host_end.sv */
// bsc_host_end.sv - test controller end: shifts vectors into chain
`timescale 1ns/1ps
`default_nettype none
`include "bsc_params.svh"

module bsc_host_end
   import bsc_pkg::*;
(
   input  wire logic     clk,        // system clock
   input  wire logic     arst_n,     // async reset, low
   bsc_link_if.host      link,       // scan link
   input  wire logic     start,      // pulse: apply vector
   input  wire logic     extest_in,  // mode for this vector
   input  wire bsc_vec_t vec_in,     // vector to shift in
   output logic          busy,       // transfer running
   output logic          done,       // pulse: transfer over
   output logic          err,        // pulse: vector refused
   output bsc_vec_t      vec_out,    // bits shifted out
   output logic          cmp_result  // comparator bit out
);

   // ---------------------------------------------------------
   // state and tck divider
   // ---------------------------------------------------------
   typedef enum logic [4:0] {
      H_IDLE  = 5'b00001,
      H_CAP   = 5'b00010,
      H_SHIFT = 5'b00100,
      H_UPD   = 5'b01000,
      H_WAIT  = 5'b10000
   } bsc_hst_t;

   bsc_hst_t   st_q;        // transfer state
   logic [3:0] div_q;       // half period counter
   logic       tck_q;       // tck level
   logic       tick;        // half period over
   logic       armed_q;     // controls set since last rise
   logic [7:0] idx_q;       // bit index
   logic [4:0] wait_q;      // settle count
   logic       en_prev_q;   // converter enable applied
   logic       need_wait_q; // vector turns converter on
   bsc_vec_t   vec_q;       // vector in flight
   logic [1:0] tdo_s_q;     // tdo synchroniser
   logic       vec_bad;     // refusal check

   assign tick = (div_q == 4'(`BSC_TCK_HALF - 1));

   // free running tck; rate sets the hold time budget
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= 4'h0;
         tck_q <= 1'b0;
      end else if (tick) begin
         div_q <= 4'h0;
         tck_q <= ~tck_q;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   // two flops on tdo
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tdo_s_q <= 2'b00;
      end else begin
         tdo_s_q <= {tdo_s_q[0], link.tdo};
      end
   end

   // ---------------------------------------------------------
   // vector checks
   // ---------------------------------------------------------
   always_comb begin
      vec_bad = 1'b0;
      // at most one negative source
      if (32'(vec_in[`BSC_POS_GND]) + 32'(vec_in[`BSC_POS_BGIN])
          + 32'(vec_in[`BSC_POS_NEG_HI:`BSC_POS_NEG_LO] != 3'h0) > 1)
         vec_bad = 1'b1;
      // sampling needs the midpoint code
      if (!vec_in[`BSC_POS_HOLD] &&
          vec_in[`BSC_POS_DAC_HI:`BSC_POS_DAC_LO] != `BSC_DAC_MID)
         vec_bad = 1'b1;
      // selected channel pin: input, no pull-up
      for (int k = 0; k < 8; k++) begin
         if (vec_in[`BSC_POS_CONVERTER_ENABLE] && vec_in[`BSC_POS_CHAN_LO + k] &&
             vec_in[3 * k + 2 -: 3] != 3'h0)
            vec_bad = 1'b1;
      end
   end

   // ---------------------------------------------------------
   // transfer sequencer
   // ---------------------------------------------------------
   // controls change on falls, tdo sampled on rises
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q            <= H_IDLE;
         armed_q         <= 1'b0;
         idx_q           <= 8'h00;
         wait_q          <= 5'h00;
         en_prev_q       <= 1'b0;
         need_wait_q     <= 1'b0;
         vec_q           <= `BSC_UPD_RST;
         vec_out         <= '0;
         done            <= 1'b0;
         err             <= 1'b0;
         link.tdi        <= 1'b0;
         link.shift_en   <= 1'b0;
         link.capture_en <= 1'b0;
         link.update_en  <= 1'b0;
         link.extest     <= 1'b0;
      end else begin
         done <= 1'b0;
         err  <= 1'b0;
         case (st_q)
            H_IDLE: begin
               if (start && vec_bad) begin
                  err <= 1'b1;
               end else if (start) begin
                  vec_q <= vec_in;
                  vec_q[`BSC_POS_RSV_A] <= 1'b0;
                  vec_q[`BSC_POS_RSV_B] <= 1'b0;
                  need_wait_q <= vec_in[`BSC_POS_CONVERTER_ENABLE] & ~en_prev_q;
                  en_prev_q   <= vec_in[`BSC_POS_CONVERTER_ENABLE];
                  link.extest <= extest_in;
                  armed_q     <= 1'b0;
                  st_q        <= H_CAP;
               end
            end
            H_WAIT: begin
               if (wait_q == 5'(`BSC_SETTLE_CYC - 1)) begin
                  done <= 1'b1;
                  st_q <= H_IDLE;
               end else begin
                  wait_q <= wait_q + 5'h01;
               end
            end
            H_CAP, H_SHIFT, H_UPD: begin
               if (tick && tck_q) begin
                  // falling: set controls for next rise
                  armed_q         <= 1'b1;
                  link.capture_en <= (st_q == H_CAP);
                  link.shift_en   <= (st_q == H_SHIFT);
                  link.update_en  <= (st_q == H_UPD);
                  link.tdi        <= vec_q[idx_q];
               end else if (tick && armed_q) begin
                  // rising: device acts, sample tdo
                  armed_q <= 1'b0;
                  if (st_q == H_CAP) begin
                     idx_q <= 8'h00;
                     st_q  <= H_SHIFT;
                  end else if (st_q == H_SHIFT) begin
                     vec_out[idx_q] <= tdo_s_q[1];
                     if (idx_q == 8'(`BSC_LEN - 1)) begin
                        st_q <= H_UPD;
                     end else begin
                        idx_q <= idx_q + 8'h01;
                     end
                  end else begin
                     wait_q <= 5'h00;
                     if (need_wait_q) begin
                        st_q <= H_WAIT;
                     end else begin
                        done <= 1'b1;
                        st_q <= H_IDLE;
                     end
                  end
               end
            end
            default: st_q <= H_IDLE;
         endcase
         if (st_q == H_IDLE || st_q == H_WAIT) begin
            link.capture_en <= 1'b0;
            link.shift_en   <= 1'b0;
            link.update_en  <= 1'b0;
         end
      end
   end

   assign link.tck   = tck_q;
   assign busy       = (st_q != H_IDLE);
   // limit checks read this from the restoring vector
   assign cmp_result = vec_out[`BSC_POS_CMP];

endmodule // bsc_host_end
`default_nettype wire

/* File: bsc_link_if.sv */
// bsc_link_if.sv - scan link between test controller and device
`timescale 1ns/1ps
`default_nettype none
interface bsc_link_if;
   logic tck;        // test clock, made by the host
   logic tdi;        // serial data into the chain
   logic tdo;        // serial data out of the chain
   logic shift_en;   // shift on next tck rise
   logic capture_en; // capture on next tck rise
   logic update_en;  // update on next tck rise
   logic extest;     // cells drive the device when high
   modport host (output tck, output tdi, output shift_en,
                 output capture_en, output update_en, output extest,
                 input tdo);
   modport dev  (input tck, input tdi, input shift_en,
                 input capture_en, input update_en, input extest,
                 output tdo);
endinterface
`default_nettype wire

/* File: bsc_params.svh */
// bsc_params.svh - chain positions, reset values and timing counts
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

// ------------------------------------------------------------
// chain geometry
// ------------------------------------------------------------
`define BSC_LEN          141
`define BSC_POS_IDLE     140
`define BSC_POS_CMP      136
`define BSC_POS_RSV_A    135
`define BSC_POS_RSV_B    132
`define BSC_POS_BGIN     131
`define BSC_POS_CONVERTER_ENABLE    130
`define BSC_POS_DAC_HI   128
`define BSC_POS_DAC_LO   119
`define BSC_POS_BYPASS   118
`define BSC_POS_GND      115
`define BSC_POS_HOLD     114
`define BSC_POS_CHAN_HI  112
`define BSC_POS_CHAN_LO  105
`define BSC_POS_NEG_HI   104
`define BSC_POS_NEG_LO   102
`define BSC_POS_PASS     101
`define BSC_POS_LATCH_PRECHARGE_N    100
// data cell of pin zero of ports B, D, C; port C pin six; port A pin seven
`define BSC_BASE_PB      96
`define BSC_BASE_PD      61
`define BSC_BASE_PC      37
`define BSC_BASE_PC6     31
`define BSC_BASE_PA7     23

// ------------------------------------------------------------
// values
// ------------------------------------------------------------
`define BSC_DAC_MID      10'h200
`define BSC_UPD_RST      ((141'h1 << 118) | (141'h1 << 114) | \
                          (141'h1 << 105) | (141'h1 << 101) | \
                          (141'h1 << 100))

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define BSC_CLK_NS       8
`define BSC_SETTLE_NS    200
`define BSC_SETTLE_CYC   ((`BSC_SETTLE_NS + `BSC_CLK_NS - 1) / `BSC_CLK_NS)
`define BSC_TCK_HALF     8
`define BSC_DUMMY_CMPS   10
`define BSC_CMP_CYC      4

`endif

/* File: bsc_pkg.sv */
// bsc_pkg.sv - shared types of the scan chain ends
package bsc_pkg;
   // pins of ports a, b, c, d in index order 0..3
   typedef logic [3:0][7:0] bsc_pins_t;
   // one full chain image
   typedef logic [140:0]    bsc_vec_t;
endpackage
